// >>> core/wkc_pkg.sv
// package: register map, field layout and timing for the wake input block
package wkc_pkg;
    localparam int         WKC_NUM_INPUTS    = 3;
    localparam int         WKC_CLK_MHZ       = 125;
    // filter times in microseconds, counts derived from clock rate
    localparam int         WKC_FILT_SHORT_US = 16;
    localparam int         WKC_FILT_LONG_US  = 64;
    localparam int         WKC_FILT_SHORT_CY = WKC_FILT_SHORT_US * WKC_CLK_MHZ;
    localparam int         WKC_FILT_LONG_CY  = WKC_FILT_LONG_US * WKC_CLK_MHZ;
    localparam int         WKC_CNT_W         = 14;
    // word offsets (byte addresses)
    localparam logic [7:0] WKC_OFS_PULL      = 8'h00;
    localparam logic [7:0] WKC_OFS_DETECT    = 8'h04;
    localparam logic [7:0] WKC_OFS_ENABLE    = 8'h08;
    localparam logic [7:0] WKC_OFS_MEAS      = 8'h0c;
    localparam logic [7:0] WKC_OFS_STATUS    = 8'h10;
    localparam logic [7:0] WKC_OFS_LEVEL     = 8'h14;
    localparam logic [7:0] WKC_OFS_CMD       = 8'h18;
    // field positions
    localparam int         WKC_SEL_W         = 2;
    localparam int         WKC_MEAS_BIT      = 0;
    localparam int         WKC_CMD_SLEEP_BIT = 0;
    localparam int         WKC_CMD_FAIL_BIT  = 1;
    // reset values
    localparam logic [5:0] WKC_PULL_RST      = 6'h00;
    localparam logic [5:0] WKC_DET_RST       = 6'h00;
    localparam logic [2:0] WKC_EN_RST        = 3'h0;
    // pull and detection encodings
    localparam logic [1:0] WKC_PULL_NONE     = 2'h0;
    localparam logic [1:0] WKC_PULL_DOWN     = 2'h1;
    localparam logic [1:0] WKC_PULL_UP       = 2'h2;
    localparam logic [1:0] WKC_PULL_AUTO     = 2'h3;
    localparam logic [1:0] WKC_DET_STATIC16  = 2'h0;
    localparam logic [1:0] WKC_DET_STATIC64  = 2'h1;
    localparam logic [1:0] WKC_DET_CYCLIC1   = 2'h2;
    localparam logic [1:0] WKC_DET_CYCLIC2   = 2'h3;

    typedef enum logic [1:0] {
        WKC_MODE_NORMAL,
        WKC_MODE_STOP,
        WKC_MODE_SLEEP,
        WKC_MODE_OTHER
    } wkc_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wkc_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wkc_wb_rsp_t;

    typedef struct packed {
        logic [2:0] pull_up;
        logic [2:0] pull_down;
        logic       measure_routing_switch;
        logic       sleep_grant;
        logic       restart_req;
    } wkc_pad_t;
endpackage

// >>> core/wkc_wake_config.sv
// wake input configuration, filtering, status and voltage measurement gating
`timescale 1ns/1ns
module wkc_wake_config #(
    parameter int FILT_SHORT = wkc_pkg::WKC_FILT_SHORT_CY,
    parameter int FILT_LONG  = wkc_pkg::WKC_FILT_LONG_CY
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire wkc_pkg::wkc_wb_req_t wb_req_i,
    output wkc_pkg::wkc_wb_rsp_t      wb_rsp_o,
    input  wire logic [2:0]          wake_level_i,
    input  wire wkc_pkg::wkc_mode_t  mode_i,
    input  wire logic                timer_one_sample_i,
    input  wire logic                timer_two_sample_i,
    output wkc_pkg::wkc_pad_t        pad_o
);
    import wkc_pkg::*;

    localparam int N = WKC_NUM_INPUTS;

    initial begin
        if (FILT_SHORT < 1 || FILT_LONG < FILT_SHORT ||
            FILT_LONG >= (1 << WKC_CNT_W)) begin
            $error("wkc_wake_config: filter counts out of range");
        end
    end

    typedef struct packed {
        logic [5:0]           pull_sel;
        logic [5:0]           det_sel;
        logic [2:0]           wake_en;
        logic                 meas_en;
        logic [2:0]           wake_stat;
        logic [2:0]           level_stat;
        logic [2:0]           stable;
        logic [2:0]           pending;
        logic [3*WKC_CNT_W-1:0] cnt;
        logic                 cmd_fail;
        wkc_wb_rsp_t          rsp;
        wkc_pad_t             pad;
    } wkc_state_t;

    wkc_state_t s_q;
    wkc_state_t s_d;

    logic        acc;
    logic        wr;
    logic [31:0] rd;
    logic [1:0]  psel;
    logic [1:0]  dsel;
    logic [WKC_CNT_W-1:0] c;
    logic [WKC_CNT_W-1:0] lim;
    logic        gated;
    logic        cyc_mode;
    logic        smp;
    logic        sleep_cmd;
    logic [2:0]  eff_en;

    always_comb begin
        s_d       = s_q;
        acc       = wb_req_i.cyc && wb_req_i.stb && !s_q.rsp.ack;
        wr        = acc && wb_req_i.we && wb_req_i.sel[0];
        rd        = 32'h0;
        sleep_cmd = 1'b0;
        psel      = 2'h0;
        dsel      = 2'h0;
        c         = '0;
        lim       = '0;
        gated     = 1'b0;
        cyc_mode  = 1'b0;
        smp       = 1'b0;
        s_d.rsp.ack = acc;

        // per-input filter, level and pull logic
        for (int i = 0; i < N; i++) begin
            psel     = s_q.pull_sel[2*i +: 2];
            dsel     = s_q.det_sel[2*i +: 2];
            c        = s_q.cnt[WKC_CNT_W*i +: WKC_CNT_W];
            gated    = s_q.meas_en && (i < 2);
            cyc_mode = dsel[1];
            smp      = !cyc_mode ? 1'b1 :
                       (dsel == WKC_DET_CYCLIC1) ? timer_one_sample_i
                                                 : timer_two_sample_i;
            lim = (dsel == WKC_DET_STATIC64) ? WKC_CNT_W'(FILT_LONG - 1)
                                             : WKC_CNT_W'(FILT_SHORT - 1);
            if (gated) begin
                // filter cleared and pulls off while measuring; stable level kept for afterwards
                s_d.pending[i]                    = 1'b0;
                s_d.cnt[WKC_CNT_W*i +: WKC_CNT_W] = '0;
                s_d.pad.pull_up[i]                = 1'b0;
                s_d.pad.pull_down[i]              = 1'b0;
            end else begin
                if (smp && wake_level_i[i] != s_q.stable[i]) begin
                    // each crossing restarts the filter window
                    if (!s_q.pending[i] || c != '0) begin
                        s_d.pending[i] = 1'b1;
                        s_d.cnt[WKC_CNT_W*i +: WKC_CNT_W] = '0;
                    end
                end
                if (s_q.pending[i]) begin
                    if (wake_level_i[i] == s_q.stable[i]) begin
                        s_d.pending[i] = 1'b0;
                        s_d.cnt[WKC_CNT_W*i +: WKC_CNT_W] = '0;
                    end else if (c >= lim) begin
                        s_d.pending[i] = 1'b0;
                        s_d.stable[i]  = wake_level_i[i];
                        s_d.cnt[WKC_CNT_W*i +: WKC_CNT_W] = '0;
                        if (s_q.wake_en[i]) begin
                            s_d.wake_stat[i] = 1'b1;
                        end
                    end else begin
                        s_d.cnt[WKC_CNT_W*i +: WKC_CNT_W] = c + 1'b1;
                    end
                end
                if (smp && (mode_i == WKC_MODE_NORMAL ||
                            mode_i == WKC_MODE_STOP)) begin
                    s_d.level_stat[i] = wake_level_i[i];
                end
                case (psel)
                    WKC_PULL_DOWN: begin
                        s_d.pad.pull_up[i]   = 1'b0;
                        s_d.pad.pull_down[i] = 1'b1;
                    end
                    WKC_PULL_UP: begin
                        s_d.pad.pull_up[i]   = 1'b1;
                        s_d.pad.pull_down[i] = 1'b0;
                    end
                    WKC_PULL_AUTO: begin
                        s_d.pad.pull_up[i]   = s_q.level_stat[i];
                        s_d.pad.pull_down[i] = !s_q.level_stat[i];
                    end
                    default: begin
                        s_d.pad.pull_up[i]   = 1'b0;
                        s_d.pad.pull_down[i] = 1'b0;
                    end
                endcase
            end
        end

        // switch closes only with measure on and in normal mode
        s_d.pad.measure_routing_switch =
            s_q.meas_en && (mode_i == WKC_MODE_NORMAL);

        // register reads
        case (wb_req_i.adr)
            WKC_OFS_PULL:   rd = {26'h0, s_q.pull_sel};
            WKC_OFS_DETECT: rd = {26'h0, s_q.det_sel};
            WKC_OFS_ENABLE: rd = {29'h0, s_q.wake_en};
            WKC_OFS_MEAS:   rd = {31'h0, s_q.meas_en};
            WKC_OFS_STATUS: rd = {29'h0, s_q.wake_stat};
            WKC_OFS_LEVEL:  rd = {29'h0, s_q.level_stat};
            WKC_OFS_CMD:    rd = {30'h0, s_q.cmd_fail, 1'b0};
            default:        rd = 32'h0;
        endcase
        s_d.rsp.dat = acc ? rd : 32'h0;

        // register writes; settings always stored, even while measuring
        eff_en = s_q.wake_en & ~{1'b0, {2{s_q.meas_en}}};
        s_d.pad.sleep_grant = 1'b0;
        s_d.pad.restart_req = 1'b0;
        if (wr) begin
            case (wb_req_i.adr)
                WKC_OFS_PULL:   s_d.pull_sel = wb_req_i.dat[5:0];
                WKC_OFS_DETECT: s_d.det_sel  = wb_req_i.dat[5:0];
                WKC_OFS_ENABLE: s_d.wake_en  = wb_req_i.dat[2:0];
                WKC_OFS_MEAS:   s_d.meas_en  = wb_req_i.dat[WKC_MEAS_BIT];
                WKC_OFS_STATUS: begin
                    // write one to clear; a new wake event in this cycle wins unless its bit was already set
                    s_d.wake_stat = (s_q.wake_stat & ~wb_req_i.dat[2:0]) |
                                    (s_d.wake_stat & ~s_q.wake_stat);
                end
                WKC_OFS_CMD: begin
                    sleep_cmd = wb_req_i.dat[WKC_CMD_SLEEP_BIT];
                    if (wb_req_i.dat[WKC_CMD_FAIL_BIT]) begin
                        s_d.cmd_fail = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (sleep_cmd) begin
            if (s_q.meas_en && s_q.wake_en[1:0] != 2'h0 &&
                eff_en == 3'h0) begin
                s_d.cmd_fail        = 1'b1;
                s_d.pad.restart_req = 1'b1;
            end else begin
                s_d.pad.sleep_grant = 1'b1;
            end
        end
        // stored settings stay untouched so clearing measure restores them
        if (!s_q.meas_en) begin
            s_d.pad.measure_routing_switch = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.pull_sel <= WKC_PULL_RST;
            s_q.det_sel  <= WKC_DET_RST;
            s_q.wake_en  <= WKC_EN_RST;
            s_q.meas_en  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_rsp_o = s_q.rsp;
    assign pad_o    = s_q.pad;
endmodule

// >>> verification/wkc_switch_model.sv
// external wake switches with optional contact bounce
`timescale 1ns/1ns
module wkc_switch_model (
    input  wire logic       clk_i,
    input  wire logic [2:0] close_i,
    input  wire logic [2:0] bounce_i,
    output logic [2:0]      level_o = 3'h0
);
    // bounce flips a contact for as long as it is held
    always @(posedge clk_i) begin
        level_o <= close_i ^ bounce_i;
    end
endmodule

// >>> verification/wkc_wake_config_assertions.sv
// port-level assertion checker for the wake configuration block
`timescale 1ns/1ns
module wkc_wake_config_assertions
    import wkc_pkg::*;
#(
    parameter int FILT_SHORT = 4,
    parameter int FILT_LONG  = 16
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire wkc_pkg::wkc_wb_req_t wb_req_i,
    input wire wkc_pkg::wkc_wb_rsp_t wb_rsp_o,
    input wire logic [2:0]           wake_level_i,
    input wire wkc_pkg::wkc_mode_t   mode_i,
    input wire logic                 timer_one_sample_i,
    input wire logic                 timer_two_sample_i,
    input wire wkc_pkg::wkc_pad_t    pad_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_single_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    ack_prompt_a: assert property (wb_req_i.cyc && wb_req_i.stb
        && !wb_rsp_o.ack |=> wb_rsp_o.ack) else $error("ack missing");
    // reset itself is the cause here, so this one is never disabled
    rst_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> pad_o == '0 && !wb_rsp_o.ack) else $error("reset not quiet");
    sw_normal_a: assert property (pad_o.measure_routing_switch
        |-> $past(mode_i) == WKC_MODE_NORMAL) else $error("switch outside normal");
    pull_excl_a: assert property ((pad_o.pull_up & pad_o.pull_down) == 3'h0)
        else $error("pull up and down together");
    meas_gate_a: assert property (pad_o.measure_routing_switch[*2]
        |-> pad_o.pull_up[1:0] == 2'h0 && pad_o.pull_down[1:0] == 2'h0)
        else $error("pull on a measured input");
    fail_excl_a: assert property (!(pad_o.sleep_grant && pad_o.restart_req))
        else $error("sleep granted and refused at once");
    fail_pulse_a: assert property (pad_o.restart_req |=> !pad_o.restart_req)
        else $error("restart request longer than a pulse");
endmodule

bind wkc_wake_config wkc_wake_config_assertions #(
    .FILT_SHORT(FILT_SHORT), .FILT_LONG(FILT_LONG)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .wake_level_i(wake_level_i), .mode_i(mode_i), .pad_o(pad_o),
    .timer_one_sample_i(timer_one_sample_i),
    .timer_two_sample_i(timer_two_sample_i));

// >>> verification/wkc_wake_config_tb_top.sv
// self-checking bench for the wake configuration block
`timescale 1ns/1ns
module wkc_wake_config_tb_top;
    import wkc_pkg::*;
    localparam int FS = 4;
    localparam int FL = 16;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wkc_wb_req_t req   = '0;
    wkc_wb_rsp_t rsp;
    wkc_mode_t   mode  = WKC_MODE_NORMAL;
    logic [2:0]  cls   = 3'h0;
    logic [2:0]  bnc   = 3'h0;
    logic [2:0]  lvl;
    logic        t1    = 1'b1;
    logic        t2    = 1'b1;
    wkc_pad_t    pad;
    logic        saw_rst = 1'b0;
    logic [32:0] top;
    logic [32:0] exp_q[$];
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #4 clk_i = ~clk_i;

    wkc_wake_config #(.FILT_SHORT(FS), .FILT_LONG(FL)) i_wkc_wake_config (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .wake_level_i(lvl), .mode_i(mode), .timer_one_sample_i(t1),
        .timer_two_sample_i(t2), .pad_o(pad));
    wkc_switch_model i_wkc_switch_model (.clk_i(clk_i), .close_i(cls),
        .bounce_i(bnc), .level_o(lvl));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // the master holds everything until it samples ack at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hf, a, d};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        exp_q.push_back(33'h0);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({1'b1, e});
        wb(1'b0, a, 32'h0);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (pad.restart_req === 1'b1)
            saw_rst = 1'b1;
        if (rsp.ack === 1'b1 && exp_q.size() > 0) begin
            top = exp_q.pop_front();
            if (top[32])
                chk("read", top[31:0], rsp.dat);
        end
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h9803));
        w(6);
        rst_i <= 1'b0;
        w(1);
        chk("pads", 32'h0, 32'(pad));
        rd(WKC_OFS_PULL, 32'h0);
        rd(WKC_OFS_MEAS, 32'h0);
        rd(8'h1c, 32'h0);
        $display("reset test done");
        // only input three wakes here; one and two stay for the fault test
        wr(WKC_OFS_ENABLE, 32'h4);
        wr(WKC_OFS_PULL, 32'h39);
        w(3);
        chk("up", 32'h2, 32'(pad.pull_up));
        chk("down", 32'h5, 32'(pad.pull_down));
        cls <= 3'h4;
        w(FS + 6);
        chk("auto", 32'h6, 32'(pad.pull_up));
        rd(WKC_OFS_STATUS, 32'h4);
        wr(WKC_OFS_STATUS, 32'h7);
        // a bounce shorter than the filter must not count
        bnc <= 3'h4;
        w(2);
        bnc <= 3'h0;
        w(FS + 4);
        rd(WKC_OFS_STATUS, 32'h0);
        rd(WKC_OFS_LEVEL, 32'h4);
        $display("pull and filter test done");
        wr(WKC_OFS_DETECT, 32'h10);
        cls <= 3'h0;
        w(FS + 4);
        rd(WKC_OFS_STATUS, 32'h0);
        w(FL);
        rd(WKC_OFS_STATUS, 32'h4);
        wr(WKC_OFS_STATUS, 32'h7);
        for (int k = 2; k < 4; k++) begin
            // only the selected timer sample is held high; the other stays idle
            t1 <= (k == 2);
            t2 <= (k == 3);
            wr(WKC_OFS_DETECT, 32'(k << 4));
            cls[2] <= ~cls[2];
            w(FS + 6);
            rd(WKC_OFS_STATUS, 32'h4);
            wr(WKC_OFS_STATUS, 32'h7);
        end
        t1 <= 1'b1;
        t2 <= 1'b1;
        $display("detect test done");
        wr(WKC_OFS_MEAS, 32'h1);
        w(3);
        chk("switch", 32'h1, 32'(pad.measure_routing_switch));
        chk("gate", 32'h0, 32'({pad.pull_up[1:0], pad.pull_down[1:0]}));
        cls[0] <= 1'b1;
        w(FS + 6);
        rd(WKC_OFS_STATUS, 32'h0);
        rd(WKC_OFS_LEVEL, 32'h0);
        wr(WKC_OFS_PULL, 32'h05);
        rd(WKC_OFS_PULL, 32'h05);
        mode <= wkc_mode_t'($urandom_range(3, 1));
        w(3);
        chk("sw off", 32'h0, 32'(pad.measure_routing_switch));
        mode <= WKC_MODE_NORMAL;
        $display("measure test done");
        wr(WKC_OFS_ENABLE, 32'h3);
        wr(WKC_OFS_CMD, 32'h1);
        w(3);
        chk("restart", 32'h1, 32'(saw_rst));
        rd(WKC_OFS_CMD, 32'h2);
        wr(WKC_OFS_CMD, 32'h2);
        wr(WKC_OFS_MEAS, 32'h0);
        w(3);
        chk("restore", 32'h3, 32'(pad.pull_down));
        rd(WKC_OFS_LEVEL, 32'h1);
        $display("fault and restore test done");
        give_verdict();
    end
endmodule
